// File: flash_array.sv
// Single-port flash cell array with registered read data.
module flash_array #(
  parameter int WORDS = 2048,
  parameter int AW    = 11,
  parameter int DW    = 8
) (
  // Clock
  input  wire logic          clk,
  // Access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  if (WORDS > (1 << AW)) begin : g_depth_check
    $error("flash_array depth exceeds address range");
  end

  // The cells keep their contents through reset, as flash does; a fresh array reads erased.
  logic [DW-1:0] cells [WORDS] = '{default: '1};

  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= cells[addr];
  end
endmodule

// File: flash_pkg.sv
// Shared constants, operation codes and request carrier of the flash sequencer.
package flash_pkg;
  localparam int          SECTORS       = 4;
  localparam int          SECTOR_BYTES  = 256;
  localparam int          PAGE_BYTES    = 16;
  localparam int          CODE_BYTES    = SECTORS * SECTOR_BYTES;
  localparam int          ARRAY_WORDS   = 2048;
  localparam int          AW            = 11;
  localparam logic [10:0] LAST_CODE     = 11'h3ff;
  localparam logic [10:0] SEC_BASE      = 11'h400;
  localparam logic [10:0] CFG_ADDR      = 11'h404;
  localparam logic [7:0]  ERASED        = 8'hff;
  localparam int          CLK_MHZ       = 100;
  localparam int          OP_TIME_US    = 2000;
  localparam int          OP_CYCLES     = OP_TIME_US * CLK_MHZ;
  localparam logic [31:0] CRC_POLY      = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam int          SEC_READ_BIT  = 0;
  localparam int          SEC_PROG_BIT  = 1;
  localparam int          ST_BUSY       = 7;
  localparam int          ST_REFUSED    = 6;
  localparam int          ST_CRC_DONE   = 5;
  localparam logic [1:0]  REG_CTRL      = 2'h0;
  localparam logic [1:0]  REG_DATA      = 2'h1;
  localparam logic [1:0]  REG_ADDR_HI   = 2'h2;
  localparam logic [1:0]  REG_ADDR_LO   = 2'h3;
  localparam int          SER_FRAME     = 32;
  localparam int          CRC_BITS      = 32;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_LOAD         = 4'h1,
    OP_PROGRAM      = 4'h2,
    OP_ERASE_BYTE   = 4'h3,
    OP_ERASE_PAGE   = 4'h4,
    OP_ERASE_SECTOR = 4'h5,
    OP_ERASE_ALL    = 4'h6,
    OP_CRC_SECTOR   = 4'h7,
    OP_CRC_ALL      = 4'h8,
    OP_SET_SECURITY = 4'h9
  } op_type;

  typedef struct packed {
    op_type     op;
    logic [9:0] addr;
    logic [7:0] data;
  } req_type;
endpackage

// File: flash_program_erase_control.sv
// Flash program/erase sequencer with firmware registers, serial programming and CRC.
// Behaviour
// - Array holds four 256-byte sectors at contiguous addresses.
// - Each sector splits into 16-byte pages for page erase and programming.
// - Sector, page and single-byte erase are separate operations.
// - A 16-byte buffer programs one to sixteen loaded bytes of one page.
// - Every program or erase finishes within 2 ms, timed internally.
// - Serial port never returns raw array bytes, only a checksum.
// - A 32-bit CRC covers one sector or the whole 1 KB on request.
// - Firmware uses control/status, data and two address registers.
// - Code reads from a read-secured sector are refused.
// - Any single byte may be erased and programmed on its own.
// - Four security bytes protect each sector independently.
// - Configuration byte is loaded at power-up and frozen afterwards.
// - Programmer drives clock and data; program, erase and checksum work in-circuit.
// - Whole-array erase clears the entire program memory at once.
module flash_program_erase_control #(
  parameter int OP_CYCLES = flash_pkg::OP_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // Firmware register port
  input  wire logic [1:0]  FW_SEL,
  input  wire logic        FW_WR,
  input  wire logic [7:0]  FW_WDATA,
  output logic      [7:0]  FW_RDATA,
  // Code read port
  input  wire logic        CR_REQ,
  input  wire logic [9:0]  CR_ADDR,
  output logic             CR_READY,
  output logic             CR_VALID,
  output logic             CR_DENIED,
  output logic      [7:0]  CR_DATA,
  // Serial programming pins
  input  wire logic        SER_SCLK,
  input  wire logic        SER_SDATA_IN,
  output logic             SER_SDATA_OUT,
  output logic             SER_SDATA_OE,
  // Status
  output logic             BUSY,
  output logic             CONFIG_VALID,
  output logic      [7:0]  CONFIG_BYTE,
  output logic      [31:0] CRC_RESULT
);
  // The wait counter is 18 bits wide and must outlast the longest array walk.
  if (OP_CYCLES < 1100 || OP_CYCLES >= (1 << 18)) begin : g_time_check
    $error("OP_CYCLES must exceed the longest array walk and fit the timer");
  end

  typedef enum logic [2:0] {
    S_BOOT  = 3'h0,
    S_IDLE  = 3'h1,
    S_WRITE = 3'h2,
    S_READ  = 3'h3,
    S_WAIT  = 3'h4
  } state_type;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? flash_pkg::CRC_POLY : 32'h0);
    end
    return r;
  endfunction

  // Sequencer state.
  state_type                state_q, state_d;
  flash_pkg::op_type        op_q, op_d;
  logic [10:0]              cur_q, cur_d, end_q, end_d, prev_q, prev_d;
  logic                     issue_q, issue_d, pend_q, pend_d;
  logic [17:0]              timer_q, timer_d;
  logic [7:0]               wval_q, wval_d;
  logic [7:0]               pbuf_q [16];
  logic [7:0]               pbuf_d [16];
  logic [15:0]              mask_q, mask_d;
  logic [5:0]               page_q, page_d;
  logic [7:0]               sec_q [4];
  logic [7:0]               sec_d [4];
  logic [7:0]               cfg_q, cfg_d;
  logic                     cfg_ok_q, cfg_ok_d;
  logic [31:0]              crc_q, crc_d;
  logic                     crc_done_q, crc_done_d, refused_q, refused_d;
  logic [7:0]               data_q, data_d, alo_q, alo_d, rdata_q, rdata_d;
  logic [1:0]               ahi_q, ahi_d;
  logic                     cr_valid_q, cr_valid_d, cr_deny_q, cr_deny_d;
  logic                     mem_we;
  logic [10:0]              mem_addr;
  logic [7:0]               mem_wdata, mem_rdata;
  flash_pkg::req_type       req;
  logic                     req_ok, fw_req, ser_req, prog_hit, cr_take;
  logic [1:0]               prog_sec;
  flash_pkg::req_type       ser_frame;

  flash_array #(
    .WORDS (flash_pkg::ARRAY_WORDS),
    .AW    (flash_pkg::AW),
    .DW    (8)
  ) u_array (
    .clk   (CLK),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Firmware takes precedence when both ports ask in the same cycle.
  assign fw_req   = FW_WR && (FW_SEL == flash_pkg::REG_CTRL) && (FW_WDATA[3:0] != 4'h0);
  assign req      = fw_req ? flash_pkg::req_type'{op: flash_pkg::op_type'(FW_WDATA[3:0]),
                               addr: {ahi_q, alo_q}, data: data_q} : ser_frame;
  assign req_ok   = (state_q == S_IDLE) && (fw_req || ser_req);
  // A page program lands in the page of the last load, so that sector is the one checked.
  assign prog_sec = (req.op == flash_pkg::OP_PROGRAM) ? page_q[5:4] : req.addr[9:8];
  assign prog_hit = sec_q[prog_sec][flash_pkg::SEC_PROG_BIT] &&
                    (req.op inside {flash_pkg::OP_PROGRAM, flash_pkg::OP_ERASE_BYTE,
                                    flash_pkg::OP_ERASE_PAGE, flash_pkg::OP_ERASE_SECTOR});
  assign cr_take  = CR_REQ && (state_q == S_IDLE) && !req_ok;

  always_comb begin
    state_d = state_q;   op_d = op_q;       cur_d = cur_q;     end_d = end_q;
    prev_d = cur_q;      issue_d = issue_q; pend_d = 1'b0;     timer_d = timer_q;
    wval_d = wval_q;     pbuf_d = pbuf_q;   mask_d = mask_q;   page_d = page_q;
    sec_d = sec_q;       cfg_d = cfg_q;     cfg_ok_d = cfg_ok_q;
    crc_d = crc_q;       crc_done_d = crc_done_q;
    refused_d = refused_q;
    data_d = data_q;     alo_d = alo_q;     ahi_d = ahi_q;
    cr_valid_d = 1'b0;   cr_deny_d = 1'b0;
    mem_we = 1'b0;       mem_addr = cur_q;  mem_wdata = wval_q;
    if (FW_WR) begin
      unique case (FW_SEL)
        flash_pkg::REG_CTRL:    if (FW_WDATA[flash_pkg::ST_REFUSED]) refused_d = 1'b0;
        flash_pkg::REG_DATA:    data_d = FW_WDATA;
        flash_pkg::REG_ADDR_HI: ahi_d = FW_WDATA[1:0];
        flash_pkg::REG_ADDR_LO: alo_d = FW_WDATA;
      endcase
    end
    unique case (FW_SEL)
      flash_pkg::REG_CTRL:    rdata_d = {state_q != S_IDLE, refused_q, crc_done_q, 1'b0, op_q};
      flash_pkg::REG_DATA:    rdata_d = data_q;
      flash_pkg::REG_ADDR_HI: rdata_d = {6'h0, ahi_q};
      flash_pkg::REG_ADDR_LO: rdata_d = alo_q;
    endcase
    unique case (state_q)
      S_BOOT, S_READ: begin
        // Reads are pipelined: data for prev_q arrives one cycle after its address.
        pend_d = issue_q;
        if (issue_q) begin
          if (cur_q == end_q) issue_d = 1'b0;
          else cur_d = cur_q + 11'h1;
        end
        if (pend_q) begin
          if (state_q == S_READ) crc_d = crc_byte(crc_q, mem_rdata);
          else if (prev_q == flash_pkg::CFG_ADDR) cfg_d = mem_rdata;
          else sec_d[prev_q[1:0]] = mem_rdata;
          if (prev_q == end_q) begin
            state_d = S_IDLE;
            if (state_q == S_READ) crc_done_d = 1'b1;
            else cfg_ok_d = 1'b1;
          end
        end
      end
      S_IDLE: begin
        if (cr_take) begin
          mem_addr = {1'b0, CR_ADDR};
          cr_valid_d = 1'b1;
          cr_deny_d = sec_q[CR_ADDR[9:8]][flash_pkg::SEC_READ_BIT];
        end
        if (req_ok) begin
          op_d = req.op;
          timer_d = '0;
          cur_d = {1'b0, req.addr};
          end_d = {1'b0, req.addr};
          wval_d = flash_pkg::ERASED;
          issue_d = 1'b1;
          state_d = S_WRITE;
          if (prog_hit) begin
            refused_d = 1'b1;
            state_d = S_IDLE;
          end else begin
            unique case (req.op)
              flash_pkg::OP_LOAD: begin
                pbuf_d[req.addr[3:0]] = req.data;
                mask_d[req.addr[3:0]] = 1'b1;
                page_d = req.addr[9:4];
                state_d = S_IDLE;
              end
              flash_pkg::OP_PROGRAM: begin
                cur_d = {1'b0, page_q, 4'h0};
                end_d = {1'b0, page_q, 4'hf};
              end
              flash_pkg::OP_ERASE_BYTE: ;
              flash_pkg::OP_ERASE_PAGE: begin
                cur_d[3:0] = 4'h0;
                end_d[3:0] = 4'hf;
              end
              flash_pkg::OP_ERASE_SECTOR: begin
                cur_d[7:0] = 8'h00;
                end_d[7:0] = 8'hff;
              end
              flash_pkg::OP_ERASE_ALL: begin
                cur_d = 11'h0;
                end_d = flash_pkg::SEC_BASE + 11'h3;
              end
              flash_pkg::OP_SET_SECURITY: begin
                cur_d = flash_pkg::SEC_BASE + {9'h0, req.addr[1:0]};
                end_d = cur_d;
                wval_d = req.data;
              end
              flash_pkg::OP_CRC_SECTOR, flash_pkg::OP_CRC_ALL: begin
                cur_d = (req.op == flash_pkg::OP_CRC_ALL) ? 11'h0
                      : {1'b0, req.addr[9:8], 8'h00};
                end_d = (req.op == flash_pkg::OP_CRC_ALL) ? flash_pkg::LAST_CODE
                      : {1'b0, req.addr[9:8], 8'hff};
                crc_d = flash_pkg::CRC_INIT;
                crc_done_d = 1'b0;
                state_d = S_READ;
              end
              default: state_d = S_IDLE;
            endcase
          end
        end
      end
      S_WRITE: begin
        timer_d = timer_q + 18'h1;
        mem_we = (op_q != flash_pkg::OP_PROGRAM) || mask_q[cur_q[3:0]];
        mem_wdata = (op_q == flash_pkg::OP_PROGRAM) ? pbuf_q[cur_q[3:0]] : wval_q;
        if (cur_q == end_q) begin
          state_d = S_WAIT;
          if (op_q == flash_pkg::OP_PROGRAM) mask_d = '0;
        end else begin
          cur_d = cur_q + 11'h1;
        end
      end
      S_WAIT: begin
        // The cell write time is held for the full window whatever the walk length.
        timer_d = timer_q + 18'h1;
        if (timer_q == 18'(OP_CYCLES - 1)) state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= S_BOOT;   op_q <= flash_pkg::OP_NONE;
      cur_q <= flash_pkg::SEC_BASE;  end_q <= flash_pkg::CFG_ADDR;
      prev_q <= '0;  issue_q <= 1'b1;  pend_q <= 1'b0;  timer_q <= '0;
      wval_q <= '0;  mask_q <= '0;  page_q <= '0;  cfg_q <= '0;  cfg_ok_q <= 1'b0;
      crc_q <= '0;  crc_done_q <= 1'b0;  refused_q <= 1'b0;
      data_q <= '0;  alo_q <= '0;  ahi_q <= '0;  rdata_q <= '0;
      cr_valid_q <= 1'b0;  cr_deny_q <= 1'b0;
      for (int i = 0; i < 16; i++) pbuf_q[i] <= '0;
      // Sectors count as fully secured until their bytes have been read.
      for (int i = 0; i < 4; i++) sec_q[i] <= 8'hff;
    end else begin
      state_q <= state_d;  op_q <= op_d;  cur_q <= cur_d;  end_q <= end_d;
      prev_q <= prev_d;  issue_q <= issue_d;  pend_q <= pend_d;  timer_q <= timer_d;
      wval_q <= wval_d;  pbuf_q <= pbuf_d;  mask_q <= mask_d;  page_q <= page_d;
      sec_q <= sec_d;  cfg_q <= cfg_d;  cfg_ok_q <= cfg_ok_d;
      crc_q <= crc_d;  crc_done_q <= crc_done_d;  refused_q <= refused_d;
      data_q <= data_d;  alo_q <= alo_d;  ahi_q <= ahi_d;  rdata_q <= rdata_d;
      cr_valid_q <= cr_valid_d;  cr_deny_q <= cr_deny_d;
    end
  end

  assign BUSY         = (state_q == S_WRITE) || (state_q == S_WAIT);
  assign FW_RDATA     = rdata_q;
  assign CR_READY     = (state_q == S_IDLE) && !req_ok;
  assign CR_VALID     = cr_valid_q;
  assign CR_DENIED    = cr_deny_q;
  assign CR_DATA      = (cr_valid_q && !cr_deny_q) ? mem_rdata : 8'h00;
  assign CONFIG_VALID = cfg_ok_q;
  assign CONFIG_BYTE  = cfg_q;
  assign CRC_RESULT   = crc_q;

  // Serial programming port: pins pass two flip-flops before any decision.
  logic [2:0]  sclk_q, sclk_d, sda_q, sda_d;
  logic [31:0] shift_q, shift_d;
  logic [5:0]  bits_q, bits_d;
  logic        frame_q, frame_d, want_q, want_d, drive_q, drive_d, req_q, req_d;
  logic [4:0]  oidx_q, oidx_d;

  assign ser_req   = req_q;
  assign ser_frame = '{op: flash_pkg::op_type'(shift_q[27:24]), addr: shift_q[17:8],
                       data: shift_q[7:0]};

  always_comb begin
    sclk_d = {sclk_q[1:0], SER_SCLK};
    sda_d = {sda_q[1:0], SER_SDATA_IN};
    shift_d = shift_q;  bits_d = bits_q;  frame_d = frame_q;  req_d = 1'b0;
    want_d = want_q;  drive_d = drive_q;  oidx_d = oidx_q;
    // Start: data falls while the clock is high and the device is not driving.
    if (!drive_q && sclk_q[1] && sda_q[2] && !sda_q[1]) begin
      frame_d = 1'b1;
      bits_d = '0;
    end else if (frame_q && sclk_q[1] && !sclk_q[2]) begin
      shift_d = {shift_q[30:0], sda_q[1]};
      bits_d = bits_q + 6'h1;
      if (bits_q == 6'(flash_pkg::SER_FRAME - 1)) begin
        frame_d = 1'b0;
        req_d = 1'b1;
        want_d = shift_d[27:24] inside {flash_pkg::OP_CRC_SECTOR, flash_pkg::OP_CRC_ALL};
      end
    end
    // Only the finished checksum is ever shifted back out; while the request is still
    // pending, the done flag belongs to the previous checksum.
    if (want_q && !req_q && crc_done_q && state_q == S_IDLE) begin
      want_d = 1'b0;
      drive_d = 1'b1;
      oidx_d = 5'(flash_pkg::CRC_BITS - 1);
    end else if (drive_q && !sclk_q[1] && sclk_q[2]) begin
      oidx_d = oidx_q - 5'h1;
      if (oidx_q == 5'h0) drive_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sclk_q <= '0;  sda_q <= 3'h7;  shift_q <= '0;  bits_q <= '0;  frame_q <= 1'b0;
      want_q <= 1'b0;  drive_q <= 1'b0;  oidx_q <= '0;  req_q <= 1'b0;
    end else begin
      sclk_q <= sclk_d;  sda_q <= sda_d;  shift_q <= shift_d;  bits_q <= bits_d;
      frame_q <= frame_d;  want_q <= want_d;  drive_q <= drive_d;  oidx_q <= oidx_d;
      req_q <= req_d;
    end
  end

  assign SER_SDATA_OE  = drive_q;
  assign SER_SDATA_OUT = drive_q & crc_q[oidx_q];

  sequence s_secured_take;
    req_ok && prog_hit;
  endsequence

  a_refuse_flag: assert property (@(posedge CLK) disable iff (!NRST)
    s_secured_take |=> refused_q && !BUSY) else $error("secured request not refused");
  a_busy_window: assert property (@(posedge CLK) disable iff (!NRST)
    BUSY |-> timer_q < 18'(OP_CYCLES)) else $error("operation overran its window");
  a_busy_ignore: assert property (@(posedge CLK) disable iff (!NRST)
    BUSY && fw_req |=> $stable(op_q)) else $error("request taken while busy");
  a_read_deny: assert property (@(posedge CLK) disable iff (!NRST)
    cr_take && sec_q[CR_ADDR[9:8]][flash_pkg::SEC_READ_BIT] |=> CR_VALID && CR_DENIED
      && CR_DATA == 8'h00) else $error("secured code read returned data");
  a_cfg_frozen: assert property (@(posedge CLK) disable iff (!NRST)
    CONFIG_VALID |=> CONFIG_VALID && $stable(CONFIG_BYTE)) else $error("config changed");
  a_erase_value: assert property (@(posedge CLK) disable iff (!NRST)
    mem_we && op_q inside {flash_pkg::OP_ERASE_BYTE, flash_pkg::OP_ERASE_PAGE,
      flash_pkg::OP_ERASE_SECTOR, flash_pkg::OP_ERASE_ALL} |-> mem_wdata == flash_pkg::ERASED)
    else $error("erase wrote a non-erased value");
  a_prog_page: assert property (@(posedge CLK) disable iff (!NRST)
    mem_we && op_q == flash_pkg::OP_PROGRAM |-> cur_q[9:4] == page_q && mask_q[cur_q[3:0]])
    else $error("program wrote outside the loaded page bytes");
  a_crc_out: assert property (@(posedge CLK) disable iff (!NRST)
    SER_SDATA_OE |-> crc_done_q && SER_SDATA_OUT == crc_q[oidx_q])
    else $error("serial port drove something other than the checksum");
  a_crc_finish: assert property (@(posedge CLK) disable iff (!NRST)
    state_q == S_READ && pend_q && prev_q == end_q |=> crc_done_q && state_q == S_IDLE)
    else $error("checksum walk did not finish");
endmodule

// File: flash_program_erase_control_test.sv
// Self-checking testbench for the flash program and erase sequencer.
module flash_program_erase_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OPC = 1200;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } row_type;
  logic        clk, nrst, fw_wr, cr_req, sclk, pdrv, poe;
  logic        cr_ready, cr_valid, cr_denied, dout, doe, busy, cfg_ok;
  logic [1:0]  fw_sel;
  logic [7:0]  fw_wdata, fw_rdata, cr_data, cfg, st;
  logic [9:0]  cr_addr;
  logic [31:0] crc, word;
  logic [7:0]  shadow [0:1023];
  int          miscompares, total_checks, cycles, n;
  row_type     rows [0:4] = '{'{10'h000, 8'ha5}, '{10'h0ff, 8'h3c}, '{10'h100, 8'h81},
                              '{10'h1f0, 8'h5a}, '{10'h2ff, 8'hc3}};
  // The data pin carries a pull-up, so a line nobody drives reads high.
  wire         line = doe ? dout : (poe ? pdrv : 1'b1);

  flash_program_erase_control #(.OP_CYCLES(OPC)) u_dut (
    .CLK(clk), .NRST(nrst), .FW_SEL(fw_sel), .FW_WR(fw_wr), .FW_WDATA(fw_wdata),
    .FW_RDATA(fw_rdata), .CR_REQ(cr_req), .CR_ADDR(cr_addr), .CR_READY(cr_ready),
    .CR_VALID(cr_valid), .CR_DENIED(cr_denied), .CR_DATA(cr_data), .SER_SCLK(sclk),
    .SER_SDATA_IN(line), .SER_SDATA_OUT(dout), .SER_SDATA_OE(doe), .BUSY(busy),
    .CONFIG_VALID(cfg_ok), .CONFIG_BYTE(cfg), .CRC_RESULT(crc));
  serial_programmer_model u_prog (.clk(clk), .line(line), .sclk(sclk), .drv(pdrv), .drv_oe(poe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    cycles = 0;
    while (cycles < 60000) begin
      @(posedge clk);
      cycles++;
    end
    miscompares++;
    report_and_stop;
  end

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // The trailing tick keeps the strobe from being set twice in one time step.
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    fw_sel   = sel;
    fw_wdata = d;
    fw_wr    = 1'b1;
    tick;
    fw_wr = 1'b0;
    tick;
  endtask

  task automatic rd(input logic [1:0] sel);
    fw_sel = sel;
    tick;
    st = fw_rdata;
  endtask

  task automatic idle;
    n = 0;
    rd(flash_pkg::REG_CTRL);
    while (st[flash_pkg::ST_BUSY] !== 1'b0 && n < 3000) begin
      rd(flash_pkg::REG_CTRL);
      n++;
    end
    check(n < 3000, 1'b1);
  endtask

  task automatic op(input flash_pkg::op_type o, input logic [9:0] a, input logic [7:0] d);
    wr(flash_pkg::REG_ADDR_HI, {6'h00, a[9:8]});
    wr(flash_pkg::REG_ADDR_LO, a[7:0]);
    wr(flash_pkg::REG_DATA, d);
    wr(flash_pkg::REG_CTRL, {4'h0, o});
    idle;
  endtask

  task automatic cread(input logic [9:0] a, input logic den, input logic [7:0] d);
    cr_req  = 1'b1;
    cr_addr = a;
    n       = 0;
    #7;
    while (cr_ready !== 1'b1 && n < 100) begin
      tick;
      #7;
      n++;
    end
    tick;
    cr_req = 1'b0;
    #6;
    check(cr_valid, 1'b1);
    check(cr_denied, den);
    check(cr_data, d);
    tick;
  endtask

  task automatic rst;
    nrst = 1'b0;
    repeat (3) tick;
    check({busy, cr_valid, cfg_ok, doe, fw_rdata}, 12'h000);
    nrst = 1'b1;
    n    = 0;
    while (cfg_ok !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    check(cfg_ok, 1'b1);
  endtask

  function automatic logic [31:0] crc_of(input int first, input int count);
    logic [31:0] c;
    c = flash_pkg::CRC_INIT;
    for (int i = 0; i < count; i++)
      for (int b = 7; b >= 0; b--)
        c = (c[31] ^ shadow[first+i][b]) ? {c[30:0], 1'b0} ^ flash_pkg::CRC_POLY : {c[30:0], 1'b0};
    return c;
  endfunction

  initial begin
    {nrst, fw_wr, cr_req, fw_sel, fw_wdata, cr_addr} = '0;
    miscompares  = 0;
    total_checks = 0;
    rst;
    op(flash_pkg::OP_ERASE_ALL, 10'h000, 8'h00);
    for (int i = 0; i < 1024; i++) shadow[i] = flash_pkg::ERASED;
    // Sector 3 becomes read and program protected after the next reset.
    for (int i = 0; i < 4; i++)
      op(flash_pkg::OP_SET_SECURITY, 10'(i), (i == 3) ? 8'h03 : 8'h00);
    rst;
    cread(10'h155, 1'b0, 8'hff);
    foreach (rows[r]) begin
      op(flash_pkg::OP_LOAD, rows[r].addr, rows[r].data);
      op(flash_pkg::OP_PROGRAM, rows[r].addr, 8'h00);
      shadow[rows[r].addr] = rows[r].data;
      cread(rows[r].addr, 1'b0, rows[r].data);
    end
    for (int i = 0; i < 16; i++) op(flash_pkg::OP_LOAD, 10'(10'h230 + i), 8'(8'h10 + i));
    op(flash_pkg::OP_PROGRAM, 10'h230, 8'h00);
    for (int i = 0; i < 16; i++) cread(10'(10'h230 + i), 1'b0, 8'(8'h10 + i));
    op(flash_pkg::OP_ERASE_PAGE, 10'h235, 8'h00);
    cread(10'h230, 1'b0, 8'hff);
    cread(10'h23f, 1'b0, 8'hff);
    cread(10'h2ff, 1'b0, 8'hc3);
    op(flash_pkg::OP_ERASE_BYTE, 10'h000, 8'h00);
    shadow[10'h000] = flash_pkg::ERASED;
    cread(10'h000, 1'b0, 8'hff);
    op(flash_pkg::OP_ERASE_SECTOR, 10'h1f0, 8'h00);
    for (int i = 0; i < 256; i++) shadow[10'h100 + i] = flash_pkg::ERASED;
    cread(10'h100, 1'b0, 8'hff);
    cread(10'h1f0, 1'b0, 8'hff);
    cread(10'h0ff, 1'b0, 8'h3c);
    op(flash_pkg::OP_LOAD, 10'h0fe, 8'h77);
    op(flash_pkg::OP_PROGRAM, 10'h0fe, 8'h00);
    shadow[10'h0fe] = 8'h77;
    // A sector erase sent while busy would wipe 0x0fe if it were taken.
    wr(flash_pkg::REG_ADDR_LO, 8'hff);
    wr(flash_pkg::REG_CTRL, {4'h0, flash_pkg::OP_ERASE_BYTE});
    wr(flash_pkg::REG_CTRL, {4'h0, flash_pkg::OP_ERASE_SECTOR});
    cr_req = 1'b1;
    #6;
    check(cr_ready, 1'b0);
    tick;
    cr_req = 1'b0;
    n = 4;
    while (busy === 1'b1 && n < 5000) begin
      tick;
      n++;
    end
    check(n >= OPC - 4 && n <= OPC + 4, 1'b1);
    cread(10'h0ff, 1'b0, 8'hff);
    shadow[10'h0ff] = flash_pkg::ERASED;
    cread(10'h0fe, 1'b0, 8'h77);
    op(flash_pkg::OP_ERASE_BYTE, 10'h300, 8'h00);
    check(st[flash_pkg::ST_REFUSED], 1'b1);
    check(busy, 1'b0);
    cread(10'h300, 1'b1, 8'h00);
    wr(flash_pkg::REG_CTRL, 8'h40);
    rd(flash_pkg::REG_CTRL);
    check(st[flash_pkg::ST_REFUSED], 1'b0);
    op(flash_pkg::OP_CRC_SECTOR, 10'h000, 8'h00);
    rd(flash_pkg::REG_CTRL);
    check(st[flash_pkg::ST_CRC_DONE], 1'b1);
    check(crc, crc_of(0, 256));
    u_prog.send_frame(4'h3, 10'h2ff, 8'h00);
    repeat (5) tick;
    idle;
    shadow[10'h2ff] = flash_pkg::ERASED;
    cread(10'h2ff, 1'b0, 8'hff);
    u_prog.send_frame(4'h8, 10'h000, 8'h00);
    repeat (5) tick;
    idle;
    repeat (1200) tick;
    check(doe, 1'b1);
    u_prog.read_word(word);
    check(word, crc_of(0, 1024));
    check(crc, crc_of(0, 1024));
    check(doe, 1'b0);
    report_and_stop;
  end
endmodule

// File: serial_programmer_model.sv
// Behavioural model of the external programmer on the two-wire serial port.
module serial_programmer_model (
  // Timing reference
  input  wire logic clk,
  // Resolved data line
  input  wire logic line,
  // Programmer drive
  output logic      sclk,
  output logic      drv,
  output logic      drv_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // The clock stands still low between frames.
  initial begin
    sclk   = 1'b0;
    drv    = 1'b1;
    drv_oe = 1'b0;
  end

  // Five core cycles keep every phase above the three-cycle minimum.
  task automatic half;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Data only changes while the clock is low, so no bit looks like a start.
  task automatic send_frame(input logic [3:0] op, input logic [9:0] addr, input logic [7:0] data);
    logic [31:0] frame;
    frame  = {4'h0, op, 6'h00, addr, data};
    // The last frame may have left data low; the start edge needs a high level to fall from.
    drv    = 1'b1;
    drv_oe = 1'b1;
    half;
    sclk = 1'b1;
    half;
    drv = 1'b0;
    half;
    sclk = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      half;
      drv = frame[i];
      half;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
    end
    half;
    drv_oe = 1'b0;
  endtask

  // Only a checksum word can come back; there is no raw read frame.
  task automatic read_word(output logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      w[i] = line;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
      half;
    end
  endtask
endmodule
